// ===== include/eifd_regs.svh
/*
 * Timing figures and reset values for the event input function decoder.
 * Assumes a 50 MHz system clock; cycle counts are derived in the modules.
 */
`ifndef EIFD_REGS_SVH
`define EIFD_REGS_SVH

// System clock in kHz
`define EIFD_CLK_KHZ       50000
// Least persistence for a recognised change, ms
`define EIFD_CHANGE_MS     50
// Least persistence for levels used by logic operations, ms
`define EIFD_LOGIC_MS      250
// Reset value of both assignments (no function)
`define EIFD_ASSIGN_RST    4'h0
// Reset value of the key-selected set point
`define EIFD_SP_RST        2'h0

`endif

// ===== include/eifd_pkg.sv
/*
 * Types for the event input function decoder.
 * Assumes eifd_regs.svh is available on the include path.
 */
package eifd_pkg;

  // Function held by an event input assignment
  typedef enum logic [3:0] {
    EIFD_FN_NONE     = 4'h0,
    EIFD_FN_RUN_STOP = 4'h1,
    EIFD_FN_AUTO_MAN = 4'h2,
    EIFD_FN_PROG     = 4'h3,
    EIFD_FN_INVERT   = 4'h4,
    EIFD_FN_TUNE_FUL = 4'h5,
    EIFD_FN_TUNE_RED = 4'h6,
    EIFD_FN_LOCK     = 4'h7,
    EIFD_FN_LATCH    = 4'h8
  } eifd_func_e;

  typedef logic [1:0] eifd_sp_t;

endpackage : eifd_pkg

// ===== verilog/eifd_filter.sv
/*
 * One event input: two-stage synchroniser and persistence filter.
 * Assumes the input is an asynchronous contact level; one clock, sync reset.
 */
`timescale 1ns/100ps
module eifd_filter
  import eifd_pkg::*;
#(
  parameter int CHANGE_CYCLES = 2500000,
  parameter int LOGIC_CYCLES  = 12500000
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  // Contact pin
  input  wire logic i_pin,
  // Filtered levels
  output logic      o_level,
  output logic      o_logic_level
);

  localparam int CW = $clog2(LOGIC_CYCLES + 1);

  logic          sync1_q;
  logic          sync2_q;
  logic          prev_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Cycles the synchronised level has held unchanged
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else if (sync2_q != prev_q) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(LOGIC_CYCLES)) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_level       <= 1'b0;
      o_logic_level <= 1'b0;
    end else begin
      if (sync2_q == prev_q && cnt_q >= CW'(CHANGE_CYCLES - 1)) begin
        o_level <= prev_q;
      end
      if (sync2_q == prev_q && cnt_q >= CW'(LOGIC_CYCLES - 1)) begin
        o_logic_level <= prev_q;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  filt_change_a: assert property ($changed(o_level) |-> $past(cnt_q) >= CW'(CHANGE_CYCLES - 1))
    else $error("Level changed before persistence time");
  filt_logic_a: assert property ($changed(o_logic_level) |-> $past(cnt_q) >= CW'(LOGIC_CYCLES - 1))
    else $error("Logic level changed before persistence time");

endmodule : eifd_filter

// ===== verilog/eifd_top.sv
/*
 * Event input function decoder: set point selection and event functions.
 * Assumes two contact inputs on pins and plain configuration ports on the
 * system clock; one clock, synchronous active-low reset.
 */
// What this block does
// - Select count one: input A off picks set point 0, on picks 1.
// - Select count two: index is {input B, input A}, set points 0 to 3.
// - Key control picks the set point equal to the stored key value.
// - Key selection acts with count zero and enable; without inputs, enable alone.
// - Each assignment encodes one of nine functions, none included.
// - A non-none function may sit on one input only; duplicates are refused.
// - Changes count after 50 ms persistence; logic-operation levels after 250 ms.
// - Run/stop input on stops control, off runs it unless a program reset has stopped it; alarms keep working.
// - Stopped indicator is active while control is stopped.
// - Auto/manual input on gives manual with its indicator, off gives auto.
// - Program start on starts the program; off resets, stops, clears end output.
// - Program start is accepted with pattern off but then has no effect.
// - Invert input flips the configured direct/reverse action while on.
// - Full-deviation tuning runs on turn-on and cancels on turn-off.
// - Reduced-deviation tuning runs on turn-on and cancels on turn-off.
// - Reduced-deviation tuning stays disabled under heating/cooling control.
// - Setting-change lock input on blocks setting changes, off permits them.
// - Alarm-latch cancel input on clears all latched alarms.
`timescale 1ns/100ps
`include "eifd_regs.svh"
module eifd_top
  import eifd_pkg::*;
#(
  parameter int CHANGE_CYCLES = `EIFD_CHANGE_MS * `EIFD_CLK_KHZ,
  parameter int LOGIC_CYCLES  = `EIFD_LOGIC_MS * `EIFD_CLK_KHZ
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  // Contact pins
  input  wire logic       i_event_a,
  input  wire logic       i_event_b,
  // Configuration
  input  wire logic       i_has_event_inputs,
  input  wire logic [1:0] i_setpoint_select_count,
  input  wire logic       i_key_setpoint_en,
  input  wire logic       i_key_sp_wr,
  input  wire eifd_sp_t   i_key_sp_val,
  input  wire logic       i_assign_wr_a,
  input  wire logic       i_assign_wr_b,
  input  wire eifd_func_e i_assign_val,
  input  wire logic       i_program_pattern_on,
  input  wire logic       i_heat_cool_mode,
  input  wire logic       i_cfg_reverse_action,
  input  wire logic       i_program_end_set,
  // Configuration state
  output eifd_func_e      o_event_input_assign_a,
  output eifd_func_e      o_event_input_assign_b,
  output eifd_sp_t        o_key_setpoint_select,
  output logic            o_assign_refused,
  // Decoded functions
  output eifd_sp_t        o_setpoint_index,
  output logic            o_control_stopped,
  output logic            o_stop_indicator,
  output logic            o_manual_mode,
  output logic            o_manual_indicator,
  output logic            o_program_run,
  output logic            o_program_reset,
  output logic            o_program_end,
  output logic            o_reverse_action,
  output logic            o_full_tune_run,
  output logic            o_full_tune_start,
  output logic            o_full_tune_cancel,
  output logic            o_red_tune_run,
  output logic            o_red_tune_start,
  output logic            o_red_tune_cancel,
  output logic            o_setting_lock,
  output logic            o_alarm_latch_clear,
  output logic            o_logic_level_a,
  output logic            o_logic_level_b
);

  logic lvl_a;
  logic lvl_b;
  logic lgc_a;
  logic lgc_b;
  logic use_a;
  logic use_b;
  logic key_eff;
  logic f_stop;
  logic f_man;
  logic f_prog;
  logic f_inv;
  logic f_full;
  logic f_red;
  logic f_lock;
  logic f_latch;
  logic prog_q;
  logic full_q;
  logic red_q;
  logic prog_stop_q;
  logic bad_code;

  eifd_filter #(
    .CHANGE_CYCLES (CHANGE_CYCLES),
    .LOGIC_CYCLES  (LOGIC_CYCLES)
  ) u_filt_a (
    .i_sys_clk     (i_sys_clk),
    .i_rstn        (i_rstn),
    .i_pin         (i_event_a),
    .o_level       (lvl_a),
    .o_logic_level (lgc_a)
  );

  eifd_filter #(
    .CHANGE_CYCLES (CHANGE_CYCLES),
    .LOGIC_CYCLES  (LOGIC_CYCLES)
  ) u_filt_b (
    .i_sys_clk     (i_sys_clk),
    .i_rstn        (i_rstn),
    .i_pin         (i_event_b),
    .o_level       (lvl_b),
    .o_logic_level (lgc_b)
  );

  // Level of whichever free input holds function f
  function automatic logic fn_level(input eifd_func_e f, input eifd_func_e fa, input eifd_func_e fb,
                                    input logic ua, input logic ub, input logic la, input logic lb);
    fn_level = (ua && fa == f && la) || (ub && fb == f && lb);
  endfunction : fn_level

  // Inputs not taken by set point selection carry their functions
  assign use_a   = (i_setpoint_select_count == 2'h0);
  assign use_b   = (i_setpoint_select_count <= 2'h1);
  assign key_eff = i_key_setpoint_en && (!i_has_event_inputs || i_setpoint_select_count == 2'h0);
  // Codes past the last function are refused
  assign bad_code = (i_assign_val > EIFD_FN_LATCH);

  assign f_stop  = fn_level(EIFD_FN_RUN_STOP, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b);
  assign f_man   = fn_level(EIFD_FN_AUTO_MAN, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b);
  assign f_prog  = fn_level(EIFD_FN_PROG, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b) && i_program_pattern_on;
  assign f_inv   = fn_level(EIFD_FN_INVERT, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b);
  assign f_full  = fn_level(EIFD_FN_TUNE_FUL, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b);
  assign f_red   = fn_level(EIFD_FN_TUNE_RED, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b) && !i_heat_cool_mode;
  assign f_lock  = fn_level(EIFD_FN_LOCK, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b);
  assign f_latch = fn_level(EIFD_FN_LATCH, o_event_input_assign_a, o_event_input_assign_b,
                            use_a, use_b, lvl_a, lvl_b);

  // Assignment store with duplicate refusal; A wins a same-cycle tie
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_event_input_assign_a <= eifd_func_e'(`EIFD_ASSIGN_RST);
      o_event_input_assign_b <= eifd_func_e'(`EIFD_ASSIGN_RST);
      o_assign_refused       <= 1'b0;
    end else begin
      o_assign_refused <= 1'b0;
      if (i_assign_wr_a) begin
        if (bad_code || (i_assign_val != EIFD_FN_NONE && i_assign_val == o_event_input_assign_b)) begin
          o_assign_refused <= 1'b1;
        end else begin
          o_event_input_assign_a <= i_assign_val;
        end
      end
      if (i_assign_wr_b) begin
        if (bad_code || (i_assign_val != EIFD_FN_NONE
                         && (i_assign_val == o_event_input_assign_a || i_assign_wr_a))) begin
          o_assign_refused <= 1'b1;
        end else begin
          o_event_input_assign_b <= i_assign_val;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_key_setpoint_select <= `EIFD_SP_RST;
    end else if (i_key_sp_wr) begin
      o_key_setpoint_select <= i_key_sp_val;
    end
  end

  // Set point index
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_setpoint_index <= `EIFD_SP_RST;
    end else if (key_eff) begin
      o_setpoint_index <= o_key_setpoint_select;
    end else if (i_setpoint_select_count == 2'h1) begin
      o_setpoint_index <= {1'b0, lvl_a};
    end else if (i_setpoint_select_count >= 2'h2) begin
      o_setpoint_index <= {lvl_b, lvl_a};
    end else begin
      o_setpoint_index <= `EIFD_SP_RST;
    end
  end

  // Run/stop, manual, action, lock and latch levels
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_control_stopped   <= 1'b0;
      o_stop_indicator    <= 1'b0;
      o_manual_mode       <= 1'b0;
      o_manual_indicator  <= 1'b0;
      o_reverse_action    <= 1'b0;
      o_setting_lock      <= 1'b0;
      o_alarm_latch_clear <= 1'b0;
      o_logic_level_a     <= 1'b0;
      o_logic_level_b     <= 1'b0;
    end else begin
      o_control_stopped   <= f_stop || prog_stop_q;
      o_stop_indicator    <= f_stop || prog_stop_q;
      o_manual_mode       <= f_man;
      o_manual_indicator  <= f_man;
      o_reverse_action    <= i_cfg_reverse_action ^ f_inv;
      o_setting_lock      <= f_lock;
      o_alarm_latch_clear <= f_latch;
      o_logic_level_a     <= lgc_a;
      o_logic_level_b     <= lgc_b;
    end
  end

  // Simple program start/reset; end flag set wins over the reset clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      prog_q          <= 1'b0;
      prog_stop_q     <= 1'b0;
      o_program_run   <= 1'b0;
      o_program_reset <= 1'b0;
      o_program_end   <= 1'b0;
    end else begin
      prog_q          <= f_prog;
      o_program_run   <= f_prog;
      o_program_reset <= prog_q && !f_prog;
      if (prog_q && !f_prog) begin
        prog_stop_q <= 1'b1;
      end else if (f_prog) begin
        prog_stop_q <= 1'b0;
      end
      if (i_program_end_set) begin
        o_program_end <= 1'b1;
      end else if (prog_q && !f_prog) begin
        o_program_end <= 1'b0;
      end
    end
  end

  // Tuning execute/cancel edges
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      full_q             <= 1'b0;
      red_q              <= 1'b0;
      o_full_tune_run    <= 1'b0;
      o_full_tune_start  <= 1'b0;
      o_full_tune_cancel <= 1'b0;
      o_red_tune_run     <= 1'b0;
      o_red_tune_start   <= 1'b0;
      o_red_tune_cancel  <= 1'b0;
    end else begin
      full_q             <= f_full;
      red_q              <= f_red;
      o_full_tune_run    <= f_full;
      o_full_tune_start  <= f_full && !full_q;
      o_full_tune_cancel <= full_q && !f_full;
      o_red_tune_run     <= f_red;
      o_red_tune_start   <= f_red && !red_q;
      o_red_tune_cancel  <= red_q && !f_red;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sp_one_a: assert property (!key_eff && i_setpoint_select_count == 2'h1 |=> o_setpoint_index == {1'b0, $past(lvl_a)})
    else $error("Set point index wrong for one input");
  sp_two_a: assert property (!key_eff && i_setpoint_select_count == 2'h2 |=> o_setpoint_index == $past({lvl_b, lvl_a}))
    else $error("Set point index wrong for two inputs");
  sp_key_a: assert property (key_eff |=> o_setpoint_index == $past(o_key_setpoint_select))
    else $error("Key set point not applied");
  key_gate_a: assert property (i_has_event_inputs && i_setpoint_select_count != 2'h0 |-> !key_eff)
    else $error("Key selection active with inputs in use");
  dup_refuse_a: assert property (i_assign_wr_a && !i_assign_wr_b && i_assign_val != EIFD_FN_NONE
                                 && i_assign_val == o_event_input_assign_b
                                 |=> o_assign_refused && $stable(o_event_input_assign_a))
    else $error("Duplicate assignment accepted");
  no_dup_a: assert property (o_event_input_assign_a == EIFD_FN_NONE
                             || o_event_input_assign_a != o_event_input_assign_b)
    else $error("Function held by both inputs");
  code_ok_a: assert property (o_event_input_assign_a <= EIFD_FN_LATCH && o_event_input_assign_b <= EIFD_FN_LATCH)
    else $error("Assignment holds an unknown function code");
  stop_ind_a: assert property (o_stop_indicator == o_control_stopped)
    else $error("Stop indicator disagrees with control state");
  stop_in_a: assert property (f_stop |=> o_control_stopped)
    else $error("Run/stop input did not stop control");
  manual_a: assert property (f_man |=> o_manual_mode && o_manual_indicator)
    else $error("Manual mode not entered");
  prog_off_a: assert property (prog_q && !f_prog && !i_program_end_set
                               |=> o_program_reset && !o_program_end ##1 o_control_stopped)
    else $error("Program reset did not stop and clear end");
  prog_dis_a: assert property (!i_program_pattern_on |=> !o_program_run)
    else $error("Program ran with pattern off");
  invert_a: assert property ($past(i_rstn) |-> o_reverse_action == $past(i_cfg_reverse_action ^ f_inv))
    else $error("Effective action wrong");
  full_tune_a: assert property ($rose(f_full) |=> o_full_tune_start ##1 !o_full_tune_start)
    else $error("Full tuning start pulse wrong");
  red_tune_a: assert property ($fell(red_q) |-> o_red_tune_cancel)
    else $error("Reduced tuning not cancelled");
  red_hc_a: assert property (i_heat_cool_mode |=> !o_red_tune_run)
    else $error("Reduced tuning ran under heating/cooling");
  lock_a: assert property ($past(i_rstn) |-> o_setting_lock == $past(f_lock))
    else $error("Setting lock wrong");
  latch_a: assert property (f_latch |=> o_alarm_latch_clear)
    else $error("Alarm latch not cleared");

  sp_four_c: cover property (i_setpoint_select_count == 2'h2 && o_setpoint_index == 2'h3);
  refuse_c: cover property (o_assign_refused);
  prog_reset_c: cover property (o_program_reset);
  tune_c: cover property (o_full_tune_start ##[1:20] o_full_tune_cancel);

endmodule : eifd_top

// ===== tb/eifd_contacts.sv
/*
 * Switch contact model for the two event input pins.
 * Assumes the bench sets levels and chatter requests off the falling edge.
 */
`timescale 1ns/100ps
module eifd_contacts (
  // Clock
  input  wire logic       i_sys_clk,
  // Requested contact state
  input  wire logic [1:0] i_level,
  input  wire logic [1:0] i_chatter,
  // Contact pins
  output logic            o_pin_a,
  output logic            o_pin_b
);
  logic [1:0] bounce_q;

  initial bounce_q = 2'h0;
  // Chattering contact flips each cycle and never settles
  always @(negedge i_sys_clk) bounce_q <= ~bounce_q;
  assign o_pin_a = i_chatter[0] ? bounce_q[0] : i_level[0];
  assign o_pin_b = i_chatter[1] ? bounce_q[1] : i_level[1];
endmodule : eifd_contacts

// ===== tb/tb.sv
/*
 * Self-checking bench for the event input decoder with shortened filter counts.
 * Assumes eifd_top, eifd_contacts and eifd_pkg are compiled first.
 */
`timescale 1ns/100ps
module tb;
  import eifd_pkg::*;
  localparam int CH = 5;
  localparam int LG = 20;
  typedef struct { string nm; logic [3:0] exp; } eifd_note_s;
  logic       clk, rstn, has_ev, key_en, key_wr, wr_a, wr_b, pat_on, heat_cool, cfg_rev, end_set;
  logic [1:0] cnt, lvl, chat;
  eifd_sp_t   key_val, key_sel, sp_idx;
  eifd_func_e av, asg_a, asg_b;
  logic       pin_a, pin_b, refused, stopped, stop_ind, manual, man_ind, prun, pend, rev;
  logic       f_run, f_st, f_cn, r_run, r_st, r_cn, lock, latch, lla, llb, p_rst;
  int         err_count, checks_done, n_fs, n_fc, n_rs, n_rc, n_pr, n_rf;
  logic [31:0] rng;
  eifd_note_s q[$];
  event       look;
  eifd_func_e fn[7] = '{EIFD_FN_RUN_STOP, EIFD_FN_AUTO_MAN, EIFD_FN_INVERT, EIFD_FN_TUNE_FUL,
                        EIFD_FN_LOCK, EIFD_FN_LATCH, EIFD_FN_PROG};
  string      fo[7] = '{"stop", "man", "rev", "ftune", "lock", "latch", "prun"};

  eifd_contacts sw (.i_sys_clk(clk), .i_level(lvl), .i_chatter(chat), .o_pin_a(pin_a), .o_pin_b(pin_b));
  eifd_top #(.CHANGE_CYCLES(CH), .LOGIC_CYCLES(LG)) uut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_event_a(pin_a), .i_event_b(pin_b), .i_has_event_inputs(has_ev),
    .i_setpoint_select_count(cnt), .i_key_setpoint_en(key_en), .i_key_sp_wr(key_wr), .i_key_sp_val(key_val),
    .i_assign_wr_a(wr_a), .i_assign_wr_b(wr_b), .i_assign_val(av), .i_program_pattern_on(pat_on),
    .i_heat_cool_mode(heat_cool), .i_cfg_reverse_action(cfg_rev), .i_program_end_set(end_set),
    .o_event_input_assign_a(asg_a), .o_event_input_assign_b(asg_b), .o_key_setpoint_select(key_sel),
    .o_assign_refused(refused), .o_setpoint_index(sp_idx), .o_control_stopped(stopped),
    .o_stop_indicator(stop_ind), .o_manual_mode(manual), .o_manual_indicator(man_ind), .o_program_run(prun),
    .o_program_reset(p_rst), .o_program_end(pend), .o_reverse_action(rev), .o_full_tune_run(f_run),
    .o_full_tune_start(f_st), .o_full_tune_cancel(f_cn), .o_red_tune_run(r_run), .o_red_tune_start(r_st),
    .o_red_tune_cancel(r_cn), .o_setting_lock(lock), .o_alarm_latch_clear(latch), .o_logic_level_a(lla),
    .o_logic_level_b(llb));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Pulse counters so one-cycle strobes are not missed
  always @(posedge clk) begin
    if (f_st === 1'h1) n_fs++;
    if (f_cn === 1'h1) n_fc++;
    if (r_st === 1'h1) n_rs++;
    if (r_cn === 1'h1) n_rc++;
    if (p_rst === 1'h1) n_pr++;
    if (refused === 1'h1) n_rf++;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  // Paired indicator must match its status line
  function automatic logic [3:0] obs(input string nm);
    case (nm)
      "asg_a": return asg_a;
      "asg_b": return asg_b;
      "key": return 4'(key_sel);
      "refused": return 4'(n_rf);
      "nrc": return 4'(n_rc);
      "npr": return 4'(n_pr);
      "sp": return 4'(sp_idx);
      "stop": return (stopped === stop_ind) ? 4'(stopped) : 4'hx;
      "man": return (manual === man_ind) ? 4'(manual) : 4'hx;
      "rev": return 4'(rev);
      "ftune": return 4'(f_run);
      "rtune": return 4'(r_run);
      "lock": return 4'(lock);
      "latch": return 4'(latch);
      "prun": return 4'(prun);
      "pend": return 4'(pend);
      "lla": return 4'(lla);
      "llb": return 4'(llb);
      "nfs": return 4'(n_fs);
      "nfc": return 4'(n_fc);
      default: return 4'(n_rs);
    endcase
  endfunction : obs

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic note(input string nm, input logic [3:0] e);
    q.push_back('{nm, e});
  endtask : note

  task automatic peek();
    -> look;
    tick(1);
    n_rf = 0;
  endtask : peek

  task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] e);
    checks_done++;
    if (seen !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task automatic wr_asg(input logic sel_b, input eifd_func_e v);
    av = v;
    wr_a = !sel_b;
    wr_b = sel_b;
    tick(1);
    wr_a = 1'h0;
    wr_b = 1'h0;
    tick(1);
  endtask : wr_asg

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Scoreboard: oldest note against the output it names
  initial forever begin
    @(look);
    while (q.size() > 0) begin
      eifd_note_s n;
      n = q.pop_front();
      check(n.nm, obs(n.nm), n.exp); // Tag sits with each note
    end
  end

  initial begin
    #(20 * 60000);
    err_count++;
    $display("BAD watchdog expected end seen timeout");
    wrap_up();
  end

  initial begin
    rng = 32'h7bd6_bfcf;
    {rstn, has_ev, key_en, key_wr, wr_a, wr_b, pat_on, heat_cool, cfg_rev, end_set} = '0;
    {cnt, lvl, chat, key_val} = '0;
    av = EIFD_FN_NONE;
    {err_count, checks_done, n_fs, n_fc, n_rs, n_rc, n_pr, n_rf} = '0;
    tick(20);
    rstn = 1'h1;
    tick(1);
    note("asg_a", EIFD_FN_NONE);
    note("sp", 4'h0);
    peek();
    $display("Test reset done");
    for (int f = 1; f <= 8; f++) begin
      wr_asg(1'h1, EIFD_FN_NONE);
      note("refused", 4'h0);
      wr_asg(1'h0, eifd_func_e'(f));
      note("asg_a", 4'(f));
      peek();
      wr_asg(1'h1, eifd_func_e'(f));
      note("refused", 4'h1);
      note("asg_b", EIFD_FN_NONE);
      peek();
      wr_asg(1'h1, eifd_func_e'(f % 8 + 1));
      note("asg_b", 4'(f % 8 + 1));
      peek();
    end
    av = EIFD_FN_LOCK;
    wr_a = 1'h1;
    wr_b = 1'h1;
    tick(1);
    {wr_a, wr_b} = 2'h0;
    tick(1);
    note("refused", 4'h1);
    note("asg_a", EIFD_FN_LOCK);
    note("asg_b", 4'(f_mod_b()));
    peek();
    wr_asg(1'h0, eifd_func_e'(4'h9));
    note("refused", 4'h1);
    note("asg_a", EIFD_FN_LOCK);
    peek();
    $display("Test assignment done");
    wr_asg(1'h0, EIFD_FN_NONE);
    wr_asg(1'h1, EIFD_FN_NONE);
    for (int i = 0; i < 16; i++) begin
      logic [31:0] r;
      logic [1:0] e;
      r = xs();
      cnt = r[1:0];
      has_ev = r[2] | (i < 10);
      key_en = r[3];
      lvl = r[5:4];
      key_val = r[7:6];
      key_wr = 1'h1;
      tick(1);
      key_wr = 1'h0;
      tick(CH + 6);
      if (key_en && (!has_ev || cnt == 2'h0)) e = key_val;
      else if (cnt == 2'h1) e = {1'h0, lvl[0]};
      else if (cnt != 2'h0) e = lvl;
      else e = 2'h0;
      note("key", 4'(r[7:6]));
      note("sp", 4'(e));
      peek();
    end
    $display("Test selection done");
    {has_ev, cnt, lvl, key_en} = 6'h30;
    tick(LG + 6);
    lvl = 2'h1;
    tick(2);
    note("sp", 4'h0);
    peek();
    tick(CH + 3);
    note("sp", 4'h1);
    note("lla", 4'h0);
    peek();
    tick(LG);
    note("lla", 4'h1);
    chat = 2'h2;
    tick(30);
    note("sp", 4'h1);
    note("llb", 4'h0);
    peek();
    {chat, lvl, cnt} = '0;
    {pat_on, cfg_rev} = {1'h1, rng[9]};
    tick(CH + 6);
    $display("Test filter done");
    for (int i = 0; i < 7; i++) begin
      wr_asg(1'h0, EIFD_FN_NONE);
      wr_asg(1'h1, EIFD_FN_NONE);
      wr_asg(i[0], fn[i]);
      {n_fs, n_fc, n_pr} = '0;
      lvl = {i[0], !i[0]};
      tick(CH + 6);
      note(fo[i], fn[i] == EIFD_FN_INVERT ? 4'(!cfg_rev) : 4'h1);
      if (fn[i] == EIFD_FN_PROG) begin
        end_set = 1'h1;
        tick(1);
        end_set = 1'h0;
        tick(2);
        note("pend", 4'h1);
      end
      peek();
      lvl = 2'h0;
      tick(CH + 6);
      note(fo[i], fn[i] == EIFD_FN_INVERT ? 4'(cfg_rev) : 4'h0);
      if (fn[i] == EIFD_FN_PROG) note("stop", 4'h1);
      if (fn[i] == EIFD_FN_PROG) note("pend", 4'h0);
      note("npr", 4'(fn[i] == EIFD_FN_PROG));
      if (fn[i] == EIFD_FN_TUNE_FUL) note("nfs", 4'h1);
      if (fn[i] == EIFD_FN_TUNE_FUL) note("nfc", 4'h1);
      peek();
    end
    pat_on = 1'h0;
    lvl = 2'h1;
    tick(CH + 6);
    note("prun", 4'h0);
    peek();
    lvl = 2'h0;
    wr_asg(1'h0, EIFD_FN_NONE);
    wr_asg(1'h1, EIFD_FN_TUNE_RED);
    for (int h = 1; h >= 0; h--) begin
      heat_cool = h[0];
      {n_rs, n_rc} = '0;
      lvl = 2'h2;
      tick(CH + 6);
      note("rtune", 4'(!h[0]));
      note("nrs", 4'(!h[0]));
      peek();
      lvl = 2'h0;
      tick(CH + 6);
      note("nrc", 4'(!h[0]));
      peek();
    end
    $display("Test functions done");
    wrap_up();
  end

  // Same-cycle write leaves B with its previous value
  function automatic logic [3:0] f_mod_b();
    return 4'h1;
  endfunction : f_mod_b
endmodule : tb
